/* File: verilog/tbpwm_pkg.sv */
// package: register map, field layout and constants of the ten-bit pwm generator
package tbpwm_pkg;
	// register byte addresses on the avalon slave
	localparam logic [3:0] ADDR_MODULE_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_DUTY_BYTE = 4'h4;
	localparam logic [3:0] ADDR_DUTY_SHADOW_BYTE = 4'h8;
	localparam logic [3:0] ADDR_PERIOD_LIMIT = 4'hc;
	localparam logic [3:0] ADDR_PERIOD_TIMER_CONTROL = 4'h0 + 4'h0;
	// period timer control lives in its own word
	localparam logic [4:0] ADDR_TIMER_CTRL = 5'h10;
	localparam logic [4:0] ADDR_PERIOD_TIMER = 5'h14;
	localparam logic [4:0] ADDR_STATUS = 5'h18;
	// module_control field positions
	localparam int DUTY_LOW_HI_POS = 5;
	localparam int DUTY_LOW_LO_POS = 4;
	localparam logic [3:0] MODE_PWM = 4'hc;
	// period_timer_control field positions
	localparam int TIMER_ON_POS = 2;
	// prescale select codes
	localparam logic [1:0] PRESCALE_1 = 2'h0;
	localparam logic [1:0] PRESCALE_4 = 2'h1;
	// reset values
	localparam logic [7:0] MODULE_CONTROL_RST = 8'h00;
	localparam logic [7:0] PERIOD_LIMIT_RST = 8'hff;
	localparam logic [7:0] TIMER_CTRL_RST = 8'h00;
	localparam logic [7:0] DUTY_RST = 8'h00;
	// oscillator cycles per instruction cycle
	localparam int OSC_PER_INSTR = 4;
	// one avalon request, grouped
	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [31:0] writedata;
	} tbpwm_req_t;
endpackage

/* File: verilog/tbpwm_top.sv */
// design: ten-bit pwm generator with avalon-mm register slave
//
// Contract
// - period is (limit+1)*4*tosc*prescale
// - at limit match: clear timer, set pin, latch
// - duty is byte plus control bits 5:4
// - new duty used only after period ends
// - shadow byte read-only in pwm mode
// - duty double buffered in shadow and latch
// - time base: timer plus phase or prescaler
// - pin cleared when time base equals duty
// - postscaler never affects pwm period
// - high time is duty*tosc*prescale
// - duty beyond period leaves pin unchanged
// - cleared control releases the pin
// - resolution log2(4*(limit+1)), ten bits max
// - prescale choices 1, 4 and 16
// - sleep freezes timer, state and pin
`timescale 1ns/100ps
module tbpwm_top
	import tbpwm_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_NRST,
	input wire logic I_SLEEP,
	input wire logic [4:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	output logic [1:0] O_AVS_RESPONSE,
	output logic O_PWM_OUT,
	output logic O_PWM_OE
);
	// sleep is an asynchronous pin: two flip-flop synchroniser
	logic sleep_meta_q;
	logic sleep_q;
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			sleep_meta_q <= 1'b0;
			sleep_q <= 1'b0;
		end else begin
			sleep_meta_q <= I_SLEEP;
			sleep_q <= sleep_meta_q;
		end
	end

	// bus request gathered into one struct
	tbpwm_req_t req;
	assign req = '{read: I_AVS_READ, write: I_AVS_WRITE, address: I_AVS_ADDRESS, writedata: I_AVS_WRITEDATA};

	// software-visible registers, then internal counters and flags
	logic [7:0] module_control_q;
	logic [7:0] duty_byte_q;
	logic [7:0] duty_shadow_byte_q;
	logic [1:0] duty_low_latch_q;
	logic [7:0] period_limit_q;
	logic [7:0] timer_ctrl_q;
	logic [7:0] period_timer_q;
	logic [3:0] prescale_q;
	logic [1:0] phase_q;
	logic ack_q;
	logic pin_q;

	logic pwm_mode;
	logic wr_hit;
	logic step;
	logic at_limit;
	logic [9:0] time_base;
	logic [9:0] duty_buf;
	logic [9:0] duty_new;
	logic [3:0] pre_div;
	logic tick;

	// decode prescale select: 00 -> 1, 01 -> 4, 1x -> 16
	function automatic logic [3:0] pre_last(input logic [1:0] sel);
		pre_last = (sel == PRESCALE_1) ? 4'h0 : (sel == PRESCALE_4) ? 4'h3 : 4'hf;
	endfunction

	// low two time base bits: they must advance once per prescaled oscillator period
	function automatic logic [1:0] low_bits(input logic [1:0] sel, input logic [1:0] ph, input logic [3:0] pre);
		if (sel == PRESCALE_1) begin
			low_bits = ph;
		end else if (sel == PRESCALE_4) begin
			low_bits = pre[1:0];
		end else begin
			low_bits = pre[3:2];
		end
	endfunction

	assign pwm_mode = (module_control_q[3:0] == MODE_PWM);
	assign wr_hit = req.write && !ack_q && I_AVS_BYTEENABLE[0];
	assign pre_div = pre_last(timer_ctrl_q[1:0]);
	// instruction clock is one ref cycle in four; prescaler divides it further
	assign step = timer_ctrl_q[TIMER_ON_POS] && !sleep_q && (phase_q == 2'h3)
		&& (prescale_q == pre_div);
	assign at_limit = (period_timer_q == period_limit_q);
	// low two bits: oscillator phase at 1:1, else top prescaler bits
	assign time_base = {period_timer_q, low_bits(timer_ctrl_q[1:0], phase_q, prescale_q)};
	// time base advances on this edge; the pin clears as the match value is entered
	assign tick = timer_ctrl_q[TIMER_ON_POS] && !sleep_q && ((timer_ctrl_q[1:0] == PRESCALE_1)
		|| ((phase_q == 2'h3) && ((timer_ctrl_q[1:0] == PRESCALE_4) || (prescale_q[1:0] == 2'h3))));
	assign duty_buf = {duty_shadow_byte_q, duty_low_latch_q};
	assign duty_new = {duty_byte_q, module_control_q[DUTY_LOW_HI_POS], module_control_q[DUTY_LOW_LO_POS]};

	// oscillator phase counter; frozen in sleep
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			phase_q <= 2'h0;
		end else if (!sleep_q) begin
			phase_q <= phase_q + 2'h1;
		end
	end

	// prescaler counts instruction cycles while timer runs
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			prescale_q <= 4'h0;
		end else if (!timer_ctrl_q[TIMER_ON_POS]) begin
			prescale_q <= 4'h0;
		end else if (!sleep_q && phase_q == 2'h3) begin
			prescale_q <= (prescale_q == pre_div) ? 4'h0 : prescale_q + 4'h1;
		end
	end

	// period timer: wraps to zero on the step after matching the limit
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			period_timer_q <= 8'h00;
		end else if (wr_hit && req.address == ADDR_PERIOD_TIMER) begin
			period_timer_q <= req.writedata[7:0];
		end else if (step) begin
			period_timer_q <= at_limit ? 8'h00 : period_timer_q + 8'h01;
		end
	end

	// duty shadow reloads only at period end; written by software outside pwm mode
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			duty_shadow_byte_q <= DUTY_RST;
			duty_low_latch_q <= 2'h0;
		end else if (step && at_limit && pwm_mode) begin
			duty_shadow_byte_q <= duty_new[9:2];
			duty_low_latch_q <= duty_new[1:0];
		end else if (wr_hit && req.address == ADDR_DUTY_SHADOW_BYTE && !pwm_mode) begin
			duty_shadow_byte_q <= req.writedata[7:0];
		end
	end

	// pin: set at period start unless duty zero, cleared on compare match
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			pin_q <= 1'b0;
		end else if (module_control_q == 8'h00) begin
			pin_q <= 1'b0;
		end else if (pwm_mode && !sleep_q) begin
			if (step && at_limit) begin
				pin_q <= (duty_new != 10'h000);
			end else if (tick && ((time_base + 10'h001) == duty_buf)) begin
				// clearing as the time base steps onto the duty value gives duty counts of high time
				pin_q <= 1'b0;
			end
		end
	end

	// output driver: released when control is cleared or not in pwm mode
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_PWM_OUT <= 1'b0;
			O_PWM_OE <= 1'b0;
		end else begin
			O_PWM_OUT <= pin_q;
			O_PWM_OE <= pwm_mode && (module_control_q != 8'h00);
		end
	end

	// writable control registers
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			module_control_q <= MODULE_CONTROL_RST;
			duty_byte_q <= DUTY_RST;
			period_limit_q <= PERIOD_LIMIT_RST;
			timer_ctrl_q <= TIMER_CTRL_RST;
		end else if (wr_hit) begin
			unique case (req.address)
				5'(ADDR_MODULE_CONTROL): module_control_q <= {2'h0, req.writedata[5:0]};
				5'(ADDR_DUTY_BYTE): duty_byte_q <= req.writedata[7:0];
				5'(ADDR_PERIOD_LIMIT): period_limit_q <= req.writedata[7:0];
				ADDR_TIMER_CTRL: timer_ctrl_q <= {1'b0, req.writedata[6:0]};
				default: ;
			endcase
		end
	end

	// avalon answer: one wait cycle, then acknowledge with data
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			ack_q <= 1'b0;
			O_AVS_WAITREQUEST <= 1'b1;
			O_AVS_READDATA <= 32'h0000_0000;
			O_AVS_RESPONSE <= 2'h0;
		end else begin
			ack_q <= (req.read || req.write) && !ack_q;
			O_AVS_WAITREQUEST <= !((req.read || req.write) && !ack_q); // low only in the answer cycle
			O_AVS_RESPONSE <= 2'h0;
			if (req.read && !ack_q) begin
				unique case (req.address)
					5'(ADDR_MODULE_CONTROL): O_AVS_READDATA <= {24'h0, module_control_q};
					5'(ADDR_DUTY_BYTE): O_AVS_READDATA <= {24'h0, duty_byte_q};
					5'(ADDR_DUTY_SHADOW_BYTE): O_AVS_READDATA <= {24'h0, duty_shadow_byte_q};
					5'(ADDR_PERIOD_LIMIT): O_AVS_READDATA <= {24'h0, period_limit_q};
					ADDR_TIMER_CTRL: O_AVS_READDATA <= {24'h0, timer_ctrl_q};
					ADDR_PERIOD_TIMER: O_AVS_READDATA <= {24'h0, period_timer_q};
					ADDR_STATUS: O_AVS_READDATA <= {29'h0, pwm_mode, pin_q, sleep_q};
					default: begin
						O_AVS_READDATA <= 32'h0000_0000;
						O_AVS_RESPONSE <= 2'h2;
					end
				endcase
			end
		end
	end

	// checks
	sequence period_end_s;
		step && at_limit;
	endsequence

	// a new request seen while waitrequest is high
	sequence bus_take_s;
		(I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
	endsequence

	// the single answer cycle
	sequence bus_answer_s;
		!O_AVS_WAITREQUEST;
	endsequence

	timer_wrap_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		period_end_s ##0 !(wr_hit && req.address == ADDR_PERIOD_TIMER) |=> period_timer_q == 8'h00)
		else $error("timer did not wrap at limit");
	duty_latch_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		period_end_s ##0 pwm_mode |=> duty_buf == $past(duty_new))
		else $error("duty not latched at period end");
	shadow_ro_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		pwm_mode && !step |=> $stable(duty_shadow_byte_q))
		else $error("shadow changed in pwm mode");
	pin_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		pwm_mode && tick && !(step && at_limit) && (time_base + 10'h001) == duty_buf |=> !pin_q)
		else $error("pin not cleared at match");
	pin_set_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		period_end_s ##0 (pwm_mode && duty_new != 10'h000 && module_control_q != 8'h00) |=> pin_q)
		else $error("pin not set at period start");
	zero_duty_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		period_end_s ##0 (pwm_mode && duty_new == 10'h000) |=> !pin_q)
		else $error("pin set with zero duty");
	// without a time base step only a cleared control may clear a high pin
	pin_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		pin_q && pwm_mode && !tick && module_control_q != 8'h00 |=> pin_q)
		else $error("pin dropped without match");
	out_lag_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		1'b1 |=> O_PWM_OUT == $past(pin_q))
		else $error("pin output not registered level");
	mode_gate_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		!pwm_mode |=> !O_PWM_OE)
		else $error("pin driven outside pwm mode");
	shadow_write_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		wr_hit && req.address == ADDR_DUTY_SHADOW_BYTE && !pwm_mode
		|=> duty_shadow_byte_q == $past(req.writedata[7:0]))
		else $error("shadow write lost outside pwm mode");
	timer_off_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		!timer_ctrl_q[TIMER_ON_POS] && !wr_hit |=> $stable(period_timer_q))
		else $error("timer moved while off");
	sleep_phase_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		sleep_q |=> $stable(phase_q) && $stable(prescale_q))
		else $error("prescaler moved in sleep");
	bus_answer_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		bus_take_s |=> bus_answer_s)
		else $error("no answer one cycle after request");
	bus_pulse_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		bus_take_s ##1 bus_answer_s |=> O_AVS_WAITREQUEST)
		else $error("answer held longer than one cycle");
	unmapped_resp_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		bus_take_s ##0 (I_AVS_READ && I_AVS_ADDRESS == 5'h1c) |=> O_AVS_RESPONSE == 2'h2)
		else $error("unmapped read not flagged");
	duty_read_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		bus_take_s ##0 (I_AVS_READ && I_AVS_ADDRESS == 5'(ADDR_DUTY_BYTE))
		|=> O_AVS_RESPONSE == 2'h0 && O_AVS_READDATA == {24'h0, $past(duty_byte_q)})
		else $error("duty byte read wrong");
	release_pin_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		module_control_q == 8'h00 |=> !O_PWM_OE)
		else $error("pin not released");
	sleep_freeze_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		sleep_q && !wr_hit |=> $stable(period_timer_q) && $stable(pin_q))
		else $error("state moved in sleep");
	step_rate_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		step |=> !step [*3])
		else $error("timer stepped faster than instruction clock");
endmodule // tbpwm_top

/* File: verification/tbpwm_load.sv */
// partner model: external load timing pulse high time and period on the pwm pin
`timescale 1ns/100ps
module tbpwm_load (
	input wire logic i_clk,
	input wire logic i_pwm,
	input wire logic i_oe,
	output int o_high,
	output int o_period,
	output int o_rises,
	output logic o_lvl
);
	int cnt = 0;
	int rise_t = 0;
	logic prev = 1'b0;
	// pin seen only while driven as output, pulled low otherwise
	assign o_lvl = i_oe ? i_pwm : 1'b0;
	// time-stamp edges in reference clock cycles
	always @(posedge i_clk) begin
		cnt <= cnt + 1;
		if (o_lvl && !prev) begin
			o_period <= cnt - rise_t;
			rise_t <= cnt;
			o_rises <= o_rises + 1;
		end
		if (!o_lvl && prev)
			o_high <= cnt - rise_t;
		prev <= o_lvl;
	end
endmodule // tbpwm_load

/* File: verification/tb.sv */
// testbench: register access, period, duty buffering, edge duties, sleep, release
`timescale 1ns/100ps
module tb;
	import tbpwm_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic slp = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic [31:0] rv;
	logic [1:0] resp;
	logic [1:0] rr;
	logic waitreq, pwm, oe, lvl, p;
	int high_len, period_len, rises, r;
	int num_errors = 0;
	int total_checks = 0;
	tbpwm_top tbpwm_top_inst (.I_REF_CLK(clk), .I_NRST(nrst), .I_SLEEP(slp), .I_AVS_ADDRESS(addr),
		.I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hf),
		.O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .O_AVS_RESPONSE(resp),
		.O_PWM_OUT(pwm), .O_PWM_OE(oe));
	tbpwm_load tbpwm_load_inst (.i_clk(clk), .i_pwm(pwm), .i_oe(oe), .o_high(high_len),
		.o_period(period_len), .o_rises(rises), .o_lvl(lvl));
	// 10 MHz reference clock
	initial forever #50 clk = ~clk;
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	// one avalon transfer, held until waitrequest is sampled low
	task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wd <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 40);
		rv = rdata;
		rr = resp;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 40) begin
			num_errors++;
			close_out();
		end
	endtask
	task wait_rise;
		int n;
		int r0;
		r0 = rises;
		n = 0;
		while (rises == r0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000) begin
			num_errors++;
			close_out();
		end
	endtask
	task cfg(input logic [7:0] lim, input logic [7:0] tc, input logic [9:0] du);
		bus(1'b1, ADDR_TIMER_CTRL, 8'h00);
		bus(1'b1, ADDR_PERIOD_TIMER, 8'h00);
		bus(1'b1, {1'b0, ADDR_PERIOD_LIMIT}, lim);
		bus(1'b1, {1'b0, ADDR_DUTY_BYTE}, du[9:2]);
		bus(1'b1, {1'b0, ADDR_MODULE_CONTROL}, {2'b00, du[1:0], MODE_PWM});
		bus(1'b1, ADDR_TIMER_CTRL, tc);
	endtask
	task t_reset;
		bus(1'b0, {1'b0, ADDR_MODULE_CONTROL}, 8'h00);
		chk("control", rv, 32'h0);
		bus(1'b0, {1'b0, ADDR_PERIOD_LIMIT}, 8'h00);
		chk("limit", rv, 32'hff);
		bus(1'b0, ADDR_TIMER_CTRL, 8'h00);
		chk("timer ctrl", rv, 32'h0);
		bus(1'b0, 5'h1c, 8'h00);
		chk("unmapped resp", {30'h0, rr}, 32'h2);
		$display("done reset");
	endtask
	// prescale 1, 4 and 16, postscale bits set on the second row
	task t_periods;
		logic [7:0] lim [3] = '{8'h07, 8'h03, 8'h01};
		logic [7:0] tc [3] = '{8'h04, 8'h7d, 8'h06};
		int ps [3] = '{1, 4, 16};
		int du [3] = '{10, 5, 3};
		for (int i = 0; i < 3; i++) begin
			cfg(lim[i], tc[i], du[i][9:0]);
			repeat (3) wait_rise();
			chk("period", period_len, (lim[i] + 1) * 4 * ps[i]);
			chk("high", high_len, du[i] * ps[i]);
		end
		$display("done periods");
	endtask
	task t_buffer;
		cfg(8'h07, 8'h04, 10'd10);
		repeat (2) wait_rise();
		bus(1'b1, {1'b0, ADDR_DUTY_BYTE}, 8'h05);
		bus(1'b0, {1'b0, ADDR_DUTY_SHADOW_BYTE}, 8'h00);
		chk("shadow old", rv, 32'h02);
		bus(1'b1, {1'b0, ADDR_DUTY_SHADOW_BYTE}, 8'h55);
		repeat (2) wait_rise();
		bus(1'b0, {1'b0, ADDR_DUTY_SHADOW_BYTE}, 8'h00);
		chk("shadow new", rv, 32'h05);
		wait_rise();
		chk("high new", high_len, 22);
		$display("done buffer");
	endtask
	task t_edge;
		bus(1'b1, {1'b0, ADDR_DUTY_BYTE}, 8'h00);
		bus(1'b1, {1'b0, ADDR_MODULE_CONTROL}, {4'h0, MODE_PWM});
		repeat (100) @(posedge clk);
		r = rises;
		repeat (70) @(posedge clk);
		chk("zero duty rises", rises, r);
		chk("zero duty level", lvl, 1'b0);
		bus(1'b1, {1'b0, ADDR_DUTY_BYTE}, 8'hff);
		bus(1'b1, {1'b0, ADDR_MODULE_CONTROL}, {4'h3, MODE_PWM});
		repeat (100) @(posedge clk);
		r = rises;
		repeat (70) @(posedge clk);
		chk("long duty level", lvl, 1'b1);
		chk("long duty rises", rises, r);
		$display("done edge");
	endtask
	task t_sleep;
		cfg(8'h07, 8'h04, 10'd10);
		repeat (50) @(posedge clk);
		slp <= 1'b1;
		repeat (5) @(posedge clk);
		p = pwm;
		bus(1'b0, ADDR_PERIOD_TIMER, 8'h00);
		r = rv;
		repeat (40) @(posedge clk);
		bus(1'b0, ADDR_PERIOD_TIMER, 8'h00);
		chk("frozen timer", rv, r);
		chk("held pin", pwm, p);
		slp <= 1'b0;
		repeat (4) @(posedge clk);
		wait_rise();
		$display("done sleep");
	endtask
	task t_off;
		bus(1'b1, {1'b0, ADDR_MODULE_CONTROL}, 8'h00);
		repeat (3) @(posedge clk);
		chk("released", oe, 1'b0);
		$display("done off");
	endtask
	// reset, then scenarios in turn
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_periods();
		t_buffer();
		t_edge();
		t_sleep();
		t_off();
		close_out();
	end
endmodule // tb
